/* core/csd_pkg.sv */
// package of register map, field positions and reset values for the steering/shutdown block
// Behaviour
// R1 - steering bits only act in modes 00x
// R2 - steer enabled: output follows polarity-adjusted data
// R3 - steer disabled: output equals override level
// R4 - sync mode double-buffers steer enables
// R5 - shutdown status bit 7, hw/sw settable
// R6 - bit 6 enables automatic restart
// R7 - bd safe state field drives B and D
// R8 - ac safe state field drives A and C
// R9 - shutdown writes accepted while disabled
// R10 - resume only at next data rising edge
// R11 - pin and comparators shut down when low
// R12 - timer postscaled outputs shut down when high
// R13 - disabled sources ignored, enabled ones trigger
// R14 - rising dead-band n to n+1 clocks
// R15 - falling dead-band n to n+1 clocks
// R16 - zero count bypasses dead-band
// R17 - dead-band counts not touched by reset
// R18 - auto-restart clears status when sources gone
// R19 - software clear ignored while source active
// R20 - mode 001 sync, 000 async steering
// R21 - polarity bit inverts the output waveform
// R22 - shutdown levels override everything else
package csd_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [11:0] CSD_ADR_RISE = 12'hf42;
	localparam logic [11:0] CSD_ADR_FALL = 12'hf43;
	localparam logic [11:0] CSD_ADR_CTRL = 12'hf44;
	localparam logic [11:0] CSD_ADR_POL = 12'hf45;
	localparam logic [11:0] CSD_ADR_SDC = 12'hf46;
	localparam logic [11:0] CSD_ADR_SRC = 12'hf47;
	localparam logic [11:0] CSD_ADR_STR = 12'hf48;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CSD_BIT_EN = 7;
	localparam int CSD_BIT_SD = 7;
	localparam int CSD_BIT_REN = 6;
	localparam int CSD_POS_BD = 4;
	localparam int CSD_POS_AC = 2;
	localparam int CSD_BIT_IN = 5;
	localparam int CSD_POS_OVR = 4;
	// ----------------------------------------
	// reset values and encodings
	// ----------------------------------------
	localparam logic [7:0] CSD_RST_SDC = 8'h14;
	localparam logic [7:0] CSD_RST_ZERO = 8'h00;
	localparam logic [2:0] CSD_MODE_ASYNC = 3'h0;
	localparam logic [2:0] CSD_MODE_SYNC = 3'h1;
	localparam logic [1:0] CSD_SAFE_HIGH = 2'h3;
	localparam logic [1:0] CSD_SAFE_LOW = 2'h2;
	localparam logic [1:0] CSD_SAFE_TRI = 2'h1;
	localparam logic [1:0] CSD_SAFE_INACT = 2'h0;
	localparam int CSD_DB_W = 6;
endpackage : csd_pkg

/* core/csd_top.sv */
// steering, auto-shutdown and dead-band logic with a classic wishbone slave
`timescale 1ns/100ps
module csd_top
	import csd_pkg::*;
#(
	parameter int DB_W = CSD_DB_W
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [7:0] wb_dat_i,
	input wire logic wb_sel_i,
	output logic [7:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic data_in_i,
	input wire logic shutdown_pin_select_i,
	input wire logic comparator_a_out_i,
	input wire logic comparator_b_out_i,
	input wire logic timer_a_postscaled_out_i,
	input wire logic timer_b_postscaled_out_i,
	input wire logic timer_c_postscaled_out_i,
	output logic [3:0] out_o,
	output logic [3:0] out_oe_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	// restart tracker: running, held in shutdown, waiting for a data rise
	typedef enum logic [2:0] {
		CSD_RUN = 3'b001,
		CSD_HOLD = 3'b010,
		CSD_WAIT = 3'b100
	} csd_state_t;

	typedef struct packed {
		logic enable; // module enable
		logic [2:0] mode; // output mode
		logic [3:0] output_invert; // per-output polarity
		logic shutdown; // shutdown status
		logic restart_en; // automatic restart
		logic [1:0] bd_safe_state; // B/D shutdown level
		logic [1:0] ac_safe_state; // A/C shutdown level
		logic [5:0] shutdown_source_en; // source enables
		logic [3:0] override_level; // static levels
		logic [3:0] steer_wr; // software-written steer enables
		logic [3:0] steer_enable; // active steer enables
		logic data; // registered data input
		logic rise_db; // rising dead-band pending
		logic fall_db; // falling dead-band pending
		logic [DB_W-1:0] db_cnt; // dead-band counter
		csd_state_t st; // restart tracker
		logic [3:0] outv; // output levels
		logic [3:0] oe; // output enables
		logic [7:0] rdat; // read data
		logic ack; // bus ack
	} csd_regs_t;

	csd_regs_t q, d;
	// dead-band counts live outside the reset struct so reset leaves them alone
	logic [DB_W-1:0] rise_delay_count_q; // rising count
	logic [DB_W-1:0] fall_delay_count_q; // falling count

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// safe-state level for one output given its field and polarity
	function automatic logic safe_lvl(input logic [1:0] f, input logic pol);
		safe_lvl = (f == CSD_SAFE_HIGH) ? 1'b1 : (f == CSD_SAFE_LOW) ? 1'b0 : pol;
	endfunction : safe_lvl

	// safe-state drive enable
	function automatic logic safe_oe(input logic [1:0] f);
		safe_oe = (f != CSD_SAFE_TRI);
	endfunction : safe_oe

	logic bus_req; // valid new request
	logic wr; // write strobe
	logic [5:0] src_active; // raw active shutdown conditions
	logic sd_cond; // any enabled condition
	logic data_rise; // data rising edge
	logic data_fall; // data falling edge
	logic steer_mode; // steering modes selected
	logic [3:0] steer_lvl; // steering result per output
	logic in_sd; // shutdown levels forced
	logic db_busy; // dead-band in progress

	assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
	assign wr = bus_req & wb_we_i & wb_sel_i;
	// low-active and high-active sources
	assign src_active = {~comparator_b_out_i, ~comparator_a_out_i, // R11
		timer_c_postscaled_out_i, timer_b_postscaled_out_i, timer_a_postscaled_out_i, // R12
		~shutdown_pin_select_i}; // R11
	assign sd_cond = |(src_active & q.shutdown_source_en); // R13
	assign data_rise = data_in_i & ~q.data;
	assign data_fall = ~data_in_i & q.data;
	assign steer_mode = (q.mode == CSD_MODE_SYNC) || (q.mode == CSD_MODE_ASYNC); // R1 R20
	assign in_sd = q.shutdown | (q.st != CSD_RUN);
	assign db_busy = q.rise_db | q.fall_db;

	// ----------------------------------------
	// steering per output
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_steer
			// data with polarity, or the static override ignoring polarity
			assign steer_lvl[gi] = q.steer_enable[gi] ? (q.data ^ q.output_invert[gi]) // R2 R21
				: q.override_level[gi]; // R3
		end
	endgenerate

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.ack = 1'b0;
		if (ce_i)
		begin
			d.ack = bus_req;
			d.data = data_in_i;
			// register writes; shutdown fields writable even when disabled
			if (wr)
			begin
				case (wb_adr_i)
					CSD_ADR_CTRL:
					begin
						d.enable = wb_dat_i[CSD_BIT_EN];
						d.mode = wb_dat_i[2:0];
					end
					CSD_ADR_POL: d.output_invert = wb_dat_i[3:0];
					CSD_ADR_SDC:
					begin
						// clearing ignored while a condition holds
						d.shutdown = wb_dat_i[CSD_BIT_SD] | sd_cond; // R5 R9 R19
						d.restart_en = wb_dat_i[CSD_BIT_REN];
						d.bd_safe_state = wb_dat_i[CSD_POS_BD+:2];
						d.ac_safe_state = wb_dat_i[CSD_POS_AC+:2];
					end
					CSD_ADR_SRC: d.shutdown_source_en = wb_dat_i[5:0]; // R9
					CSD_ADR_STR:
					begin
						d.override_level = wb_dat_i[CSD_POS_OVR+:4];
						d.steer_wr = wb_dat_i[3:0];
					end
					default:
					begin
					end
				endcase
			end
			// hardware set wins over any clear
			if (sd_cond)
				d.shutdown = 1'b1; // R5 R13
			else if (q.restart_en && q.shutdown)
				d.shutdown = 1'b0; // R6 R18
			// steer enables: async immediate, sync at the data rise
			if (q.mode != CSD_MODE_SYNC)
				d.steer_enable = d.steer_wr;
			else if (data_rise)
				d.steer_enable = q.steer_wr; // R4
			// restart tracking
			case (q.st)
				CSD_RUN: if (d.shutdown) d.st = CSD_HOLD;
				CSD_HOLD: if (!d.shutdown) d.st = CSD_WAIT;
				CSD_WAIT:
				begin
					if (d.shutdown)
						d.st = CSD_HOLD;
					else if (data_rise)
						d.st = CSD_RUN; // R10
				end
				default: d.st = CSD_HOLD;
			endcase
			// dead-band: hold newly-active output for n clocks
			if (data_rise)
			begin
				d.rise_db = (rise_delay_count_q != '0); // R14 R16
				d.fall_db = 1'b0;
				d.db_cnt = rise_delay_count_q;
			end
			else if (data_fall)
			begin
				d.fall_db = (fall_delay_count_q != '0); // R15 R16
				d.rise_db = 1'b0;
				d.db_cnt = fall_delay_count_q;
			end
			else if (db_busy)
			begin
				d.db_cnt = q.db_cnt - 1'b1;
				if (q.db_cnt <= DB_W'(1))
				begin
					d.rise_db = 1'b0;
					d.fall_db = 1'b0;
				end
			end
			// output selection
			if (in_sd)
			begin
				// inactive-state option drives the inactive level at once, also during a dead-band
				for (int i = 0; i < 4; i++)
				begin
					logic [1:0] f;
					f = i[0] ? q.bd_safe_state : q.ac_safe_state; // R7 R8
					if (f == CSD_SAFE_INACT && db_busy)
						d.outv[i] = 1'b0 ^ q.output_invert[i];
					else
						d.outv[i] = safe_lvl(f, q.output_invert[i]); // R22
					d.oe[i] = safe_oe(f);
				end
			end
			else if (!q.enable)
			begin
				d.outv = q.output_invert;
				d.oe = 4'hf;
			end
			else if (steer_mode)
			begin
				// A/C ride the rising path, B/D the falling path
				for (int i = 0; i < 4; i++)
				begin
					logic hold;
					hold = i[0] ? q.fall_db : q.rise_db;
					d.outv[i] = (hold && q.steer_enable[i]) ? q.output_invert[i] : steer_lvl[i];
				end
				d.oe = 4'hf;
			end
			else
			begin
				d.outv = q.output_invert;
				d.oe = 4'hf;
			end
			// read data
			case (wb_adr_i)
				CSD_ADR_RISE: d.rdat = {2'h0, rise_delay_count_q};
				CSD_ADR_FALL: d.rdat = {2'h0, fall_delay_count_q};
				CSD_ADR_CTRL: d.rdat = {q.enable, 4'h0, q.mode};
				CSD_ADR_POL: d.rdat = {2'h0, q.data, 1'b0, q.output_invert};
				CSD_ADR_SDC: d.rdat = {q.shutdown, q.restart_en, q.bd_safe_state,
					q.ac_safe_state, 2'h0}; // R5
				CSD_ADR_SRC: d.rdat = {2'h0, q.shutdown_source_en};
				CSD_ADR_STR: d.rdat = {q.override_level, q.steer_wr};
				default: d.rdat = CSD_RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.shutdown <= 1'b0;
			q.bd_safe_state <= CSD_RST_SDC[CSD_POS_BD+:2];
			q.ac_safe_state <= CSD_RST_SDC[CSD_POS_AC+:2];
			q.st <= CSD_HOLD;
			q.oe <= 4'h0;
		end
		else
			q <= d;
	end

	// dead-band counts: never reset, keep value through resets
	always_ff @(posedge clk_i)
	begin
		if (ce_i && wr && wb_adr_i == CSD_ADR_RISE)
			rise_delay_count_q <= wb_dat_i[DB_W-1:0]; // R17
		if (ce_i && wr && wb_adr_i == CSD_ADR_FALL)
			fall_delay_count_q <= wb_dat_i[DB_W-1:0]; // R17
	end

	assign out_o = q.outv;
	assign out_oe_o = q.oe;
	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_source_sets_sd: assert property (@(posedge clk_i) disable iff (rst_i) // R13
		ce_i && sd_cond |=> q.shutdown)
		else $error("enabled shutdown source did not set status");
	chk_sw_clear_blocked: assert property (@(posedge clk_i) disable iff (rst_i) // R19
		ce_i && wr && wb_adr_i == CSD_ADR_SDC && sd_cond |=> q.shutdown)
		else $error("shutdown cleared while condition active");
	chk_auto_restart_clr: assert property (@(posedge clk_i) disable iff (rst_i) // R18
		ce_i && q.restart_en && q.shutdown && !sd_cond && !wr |=> !q.shutdown)
		else $error("auto restart failed to clear status");
	chk_no_auto_clr: assert property (@(posedge clk_i) disable iff (rst_i) // R6
		ce_i && !q.restart_en && q.shutdown && !wr |=> q.shutdown)
		else $error("status cleared without restart enable");
	chk_wait_rise: assert property (@(posedge clk_i) disable iff (rst_i) // R10
		q.st == CSD_WAIT && ce_i && !data_rise |=> q.st != CSD_RUN)
		else $error("resumed without a data rising edge");
	chk_sd_tri_state: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		ce_i && in_sd && q.ac_safe_state == CSD_SAFE_TRI |=> !out_oe_o[0] && !out_oe_o[2])
		else $error("a/c not released in tri-state shutdown");
	chk_sd_high: assert property (@(posedge clk_i) disable iff (rst_i) // R7
		ce_i && in_sd && q.bd_safe_state == CSD_SAFE_HIGH |=> out_o[1] && out_o[3])
		else $error("b/d not high in shutdown");
	chk_override: assert property (@(posedge clk_i) disable iff (rst_i) // R3
		ce_i && !in_sd && q.enable && steer_mode && !q.steer_enable[0]
		|=> out_o[0] == $past(q.override_level[0]))
		else $error("override level not driven");
	chk_db_bypass: assert property (@(posedge clk_i) disable iff (rst_i) // R16
		ce_i && data_rise && rise_delay_count_q == '0 |=> !q.rise_db)
		else $error("dead-band not bypassed for zero count");
	chk_sync_steer: assert property (@(posedge clk_i) disable iff (rst_i) // R4
		ce_i && q.mode == CSD_MODE_SYNC && !data_rise |=> $stable(q.steer_enable))
		else $error("sync steer changed outside data rise");
	cov_shutdown_restart: cover property (@(posedge clk_i) q.st == CSD_WAIT ##1 q.st == CSD_RUN);
	cov_rise_db: cover property (@(posedge clk_i) q.rise_db ##1 !q.rise_db);
	cov_write_steer: cover property (@(posedge clk_i) wr && wb_adr_i == CSD_ADR_STR);
endmodule : csd_top

/* dv/csd_switch_model.sv */
// model of the external switch stage fed by the four outputs
`timescale 1ns/100ps
module csd_switch_model
(
	input wire logic clk_i,
	input wire logic [3:0] out_i,
	input wire logic [3:0] oe_i,
	output logic [3:0] pin_o
);
	logic [3:0] last_q; // level each pin showed last cycle
	// --------------------------------
	// pin resolution
	// --------------------------------
	// gate inputs have no pull, so a floating pin is shown as the
	// inverse of its last level instead of a stale value
	always_ff @(posedge clk_i)
	begin
		last_q <= pin_o;
	end
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			pin_o[i] = oe_i[i] ? out_i[i] : ~last_q[i];
		end
	end
endmodule : csd_switch_model

/* dv/testbench.sv */
// self-checking bench for the steering, shutdown and dead-band block
`timescale 1ns/100ps
module testbench
	import csd_pkg::*;
;
	localparam logic [5:0] IDLE = 6'h31; // source levels that request nothing
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce = 1'b1; // clock enable, dropped only by the freeze scenario
	logic cyc = 1'b0; // drives both cyc and stb
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [7:0] wdat = 8'h00;
	logic dat_in = 1'b0;
	logic [5:0] src = IDLE; // pin, timers a..c, comparators a, b
	logic [7:0] rdat;
	logic [7:0] rd; // data taken at the ack
	logic ack;
	logic [3:0] out;
	logic [3:0] oe;
	logic [3:0] pin;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	int l0;
	int ln;
	always #10 clk_i = ~clk_i;
	csd_top i_csd_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(1'b1),
		.wb_dat_o(rdat), .wb_ack_o(ack), .data_in_i(dat_in),
		.shutdown_pin_select_i(src[0]), .comparator_a_out_i(src[4]),
		.comparator_b_out_i(src[5]), .timer_a_postscaled_out_i(src[1]),
		.timer_b_postscaled_out_i(src[2]), .timer_c_postscaled_out_i(src[3]),
		.out_o(out), .out_oe_o(oe));
	csd_switch_model i_csd_switch_model (.clk_i(clk_i), .out_i(out), .oe_i(oe), .pin_o(pin));
	// --------------------------------
	// helpers
	// --------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one classic cycle; request held until the edge that samples ack high,
	// read data taken at that same edge, then released for at least a cycle
	task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask : rdchk
	// outputs as {enables, levels}, masked where the pins float
	task automatic outs(input logic [7:0] exp, input logic [7:0] m = 8'hff);
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		chk({oe, out} & m, exp);
		// driven pins at the switch stage must show the driven level
		if (m == 8'hff)
			chk({4'h0, pin & oe}, {4'h0, exp[3:0] & exp[7:4]});
	endtask : outs
	task automatic rise();
		@(posedge clk_i);
		dat_in <= 1'b0;
		repeat (10) @(posedge clk_i);
		dat_in <= 1'b1;
	endtask : rise
	task automatic active(input logic [5:0] s);
		@(posedge clk_i);
		src <= s;
		repeat (3) @(posedge clk_i);
	endtask : active
	// cycles from a data rise until output a goes high
	task automatic lat(output int l);
		rise();
		l = 0;
		do
		begin
			@(negedge clk_i);
			l++;
		end
		while (out[0] !== 1'b1 && l < 90);
	endtask : lat
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_reset();
		rdchk(CSD_ADR_SDC, CSD_RST_SDC);
		rdchk(CSD_ADR_STR, 8'h00);
		rdchk(12'hf4f, 8'h00);
		outs(8'h00, 8'hf0);
	endtask : t_reset
	task automatic t_steer();
		wb(1'b1, CSD_ADR_RISE, 8'h00);
		wb(1'b1, CSD_ADR_FALL, 8'h00);
		wb(1'b1, CSD_ADR_STR, 8'h1a);
		wb(1'b1, CSD_ADR_SDC, 8'h38);
		rdchk(CSD_ADR_SDC, 8'h38);
		wb(1'b1, CSD_ADR_CTRL, 8'h80);
		rise();
		outs(8'hfb);
		@(posedge clk_i);
		dat_in <= 1'b0;
		outs(8'hf1);
		wb(1'b1, CSD_ADR_POL, 8'h03);
		outs(8'hf3);
		wb(1'b1, CSD_ADR_POL, 8'h00);
		wb(1'b1, CSD_ADR_CTRL, 8'h82);
		outs(8'hf0);
		wb(1'b1, CSD_ADR_CTRL, 8'h80);
		rise();
		outs(8'hfb);
	endtask : t_steer
	task automatic t_shut();
		wb(1'b1, CSD_ADR_SRC, 8'h01);
		active(IDLE ^ 6'h01);
		outs(8'hfa);
		rdchk(CSD_ADR_SDC, 8'hb8);
		wb(1'b1, CSD_ADR_SDC, 8'h38);
		rdchk(CSD_ADR_SDC, 8'hb8);
		active(IDLE);
		rdchk(CSD_ADR_SDC, 8'hb8);
		wb(1'b1, CSD_ADR_SDC, 8'h38);
		outs(8'hfa);
		rise();
		outs(8'hfb);
	endtask : t_shut
	task automatic t_auto();
		wb(1'b1, CSD_ADR_SDC, 8'h78);
		for (int i = 0; i < 6; i++)
		begin
			wb(1'b1, CSD_ADR_SRC, 8'(1 << i));
			active(IDLE ^ 6'(1 << i));
			rdchk(CSD_ADR_SDC, 8'hf8);
			active(IDLE);
			rdchk(CSD_ADR_SDC, 8'h78);
		end
		wb(1'b1, CSD_ADR_SRC, 8'h00);
		active(~IDLE);
		rdchk(CSD_ADR_SDC, 8'h78);
		active(IDLE);
	endtask : t_auto
	// a source pulse while the clock enable is low must leave no trace
	task automatic t_freeze();
		wb(1'b1, CSD_ADR_SRC, 8'h01);
		@(posedge clk_i);
		ce <= 1'b0;
		src <= IDLE ^ 6'h01;
		repeat (5) @(posedge clk_i);
		src <= IDLE;
		@(posedge clk_i);
		ce <= 1'b1;
		rdchk(CSD_ADR_SDC, 8'h78);
		wb(1'b1, CSD_ADR_SRC, 8'h00);
	endtask : t_freeze
	task automatic t_safe();
		wb(1'b1, CSD_ADR_POL, 8'h05);
		wb(1'b1, CSD_ADR_SDC, 8'h54);
		wb(1'b1, CSD_ADR_SRC, 8'h01);
		active(IDLE ^ 6'h01);
		outs(8'h00, 8'hf0);
		wb(1'b1, CSD_ADR_SDC, 8'h40);
		outs(8'hf5);
		active(IDLE);
		wb(1'b1, CSD_ADR_POL, 8'h00);
		wb(1'b1, CSD_ADR_SRC, 8'h00);
	endtask : t_safe
	task automatic t_dband();
		wb(1'b1, CSD_ADR_STR, 8'h0f);
		lat(l0);
		for (int k = 1; k < 64; k += 62)
		begin
			wb(1'b1, CSD_ADR_RISE, 8'(k));
			lat(ln);
			chk(8'((ln - l0 == k) || (ln - l0 == k + 1)), 8'h01);
		end
		wb(1'b1, CSD_ADR_FALL, 8'h2a);
		rdchk(CSD_ADR_FALL, 8'h2a);
		wb(1'b1, CSD_ADR_FALL, 8'h00);
		wb(1'b1, CSD_ADR_RISE, 8'h00);
	endtask : t_dband
	task automatic t_sync();
		wb(1'b1, CSD_ADR_CTRL, 8'h81);
		rise();
		outs(8'hff);
		wb(1'b1, CSD_ADR_STR, 8'h00);
		outs(8'hff);
		rise();
		outs(8'hf0);
	endtask : t_sync
	task automatic t_keep();
		wb(1'b1, CSD_ADR_RISE, 8'h2a);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(CSD_ADR_RISE, 8'h2a);
		rdchk(CSD_ADR_SDC, CSD_RST_SDC);
	endtask : t_keep
	// --------------------------------
	// verdict and run control
	// --------------------------------
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	// a hang counts as a mismatch
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 20000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_steer();
		t_shut();
		t_auto();
		t_freeze();
		t_safe();
		t_dband();
		t_sync();
		t_keep();
		end_of_test();
	end
endmodule : testbench
